/* File: pbmc_top.sv */
// basic mode control register of a 10/100 transceiver with its mii gating
// assumes all inputs are synchronous to SYS_CLK_IN; pads use the enables
`timescale 1ns/100ps
`include "pbmc_map.svh"
// Behaviour
// R1: reset bit restores defaults, reads one meanwhile
// R2: loopback bit enables internal loopback, default zero
// R3: 100M loopback entry blanks receive data 1300ms
// R4: speed bit one is 100M, default one
// R5: negotiation on: speed reads negotiated value
// R6: negotiation enable, default one, steers speed/duplex
// R7: power-down still answers management frames
// R8: power-down keeps mii outputs quiet
// R9: isolate ignores transmit, floats mii outputs
// R10: isolated device still answers management frames
// R11: restart bit holds one until negotiation starts
// R12: software leaves restart clear without negotiation
// R13: writing restart zero never disturbs negotiation
// R14: duplex bit written only without negotiation; code stores it on every write, reads negotiated value under negotiation
// R15: collision test echoes TX_EN onto COL
// R16: low seven bits read zero, written ignored
// R17: pin-sourced fields load strap level at reset
// R18: permanent fields ignore management writes
// R19: sixteen-bit register at management address zero
module pbmc_top #(
   parameter int DEAD_CYC = `PBMC_DEAD_CYC, // loopback blanking cycles
   parameter logic [15:0] PIN_MASK = 16'h0000 // fields taken from straps
) (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   // management pins
   input wire logic MDC_IN,
   input wire logic MDIO_IN,
   output logic MDIO_OUT,
   output logic MDIO_OE_OUT,
   // straps
   input wire logic [4:0] PHYAD_IN,
   input wire logic [15:0] STRAP_IN,
   // negotiation engine
   input wire logic ANEG_SPEED_IN,
   input wire logic ANEG_DUPLEX_IN,
   input wire logic ANEG_STARTED_IN,
   // mac side of the mii
   input wire pbmc_pkg::pbmc_tx_type MII_TX_IN,
   output pbmc_pkg::pbmc_rx_type MII_RX_OUT,
   output logic MII_OE_OUT,
   // transceiver core side
   input wire pbmc_pkg::pbmc_rx_type CORE_RX_IN,
   output pbmc_pkg::pbmc_tx_type CORE_TX_OUT,
   // control levels to the core
   output logic SOFT_RESET_OUT,
   output logic LOOPBACK_OUT,
   output logic SPEED_100_OUT,
   output logic FULL_DUPLEX_OUT,
   output logic ANEG_EN_OUT,
   output logic ANEG_RESTART_OUT,
   output logic POWER_DOWN_OUT
);
   import pbmc_pkg::*;
   localparam int SRST_CYC = `PBMC_SRST_CYC; // soft reset length
   localparam int DEAD_W = $clog2(DEAD_CYC + 1); // blanking counter width

   pbmc_ctrl_type ctrl_r; // stored control fields
   logic [15:0] strap_r; // strap levels caught in reset
   logic [7:0] srst_cnt_r; // soft reset countdown
   logic [DEAD_W-1:0] dead_cnt_r; // receive blanking countdown
   logic loop_q_r; // loopback last cycle
   logic [4:0] regad; // address of current frame
   logic wr_stb; // write frame complete
   logic [15:0] wr_data; // written word
   logic [15:0] rd_word; // word answered on reads
   logic [15:0] rd_data; // answer for the frame address
   logic wr_hit; // write to this register

   // reset value of one field: strap or fixed default
   function automatic logic field_def(input int pos, input logic fixed);
      field_def = PIN_MASK[pos] ? strap_r[pos] : fixed;
   endfunction

   // word seen by the management entity
   function automatic logic [15:0] pack_word(input pbmc_ctrl_type c,
                                             input logic spd,
                                             input logic dpx);
      logic [15:0] w;
      w = 16'h0000;
      w[`PBMC_B_RESET] = c.reset;
      w[`PBMC_B_LOOP] = c.loop;
      w[`PBMC_B_SPEED] = c.aneg ? spd : c.speed;
      w[`PBMC_B_ANEG] = c.aneg;
      w[`PBMC_B_PDN] = c.pdn;
      w[`PBMC_B_ISO] = c.iso;
      w[`PBMC_B_RESTART] = c.restart;
      w[`PBMC_B_DUPLEX] = c.aneg ? dpx : c.duplex;
      w[`PBMC_B_COLTEST] = c.coltest;
      w[`PBMC_RSVD_HI:0] = `PBMC_RST_RSVD;
      pack_word = w;
   endfunction

   // management slave; runs regardless of isolate and power-down
   pbmc_mdio u_mdio (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(RESET_N_IN),
      .mdc_in(MDC_IN),
      .mdio_in(MDIO_IN),
      .mdio_out(MDIO_OUT),
      .mdio_oe_out(MDIO_OE_OUT),
      .phyad_in(PHYAD_IN),
      .rd_data_in(rd_data),
      .regad_out(regad),
      .wr_stb_out(wr_stb),
      .wr_data_out(wr_data)
   );

   // read path: negotiated results replace speed and duplex
   assign rd_word = pack_word(ctrl_r, ANEG_SPEED_IN,
                              ANEG_DUPLEX_IN); // R5 R14 R16
   // other addresses answer zero
   assign rd_data = (regad == `PBMC_REG_ADDR) ? rd_word : 16'h0000; // R19
   assign wr_hit = wr_stb && regad == `PBMC_REG_ADDR; // R19 R7 R10

   // straps are sampled only while reset is held
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) strap_r <= STRAP_IN; // R17
   end

   // control fields: hardware reset, soft reset and writes
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN || (ctrl_r.reset && srst_cnt_r == 8'h01)) begin
         ctrl_r.reset <= `PBMC_RST_RESET; // R1
         ctrl_r.loop <= field_def(`PBMC_B_LOOP, `PBMC_RST_LOOP); // R2 R17
         ctrl_r.speed <= field_def(`PBMC_B_SPEED, `PBMC_RST_SPEED); // R4
         ctrl_r.aneg <= field_def(`PBMC_B_ANEG, `PBMC_RST_ANEG); // R6
         ctrl_r.pdn <= field_def(`PBMC_B_PDN, `PBMC_RST_PDN);
         ctrl_r.iso <= field_def(`PBMC_B_ISO, `PBMC_RST_ISO);
         ctrl_r.restart <= `PBMC_RST_RESTART;
         ctrl_r.duplex <= field_def(`PBMC_B_DUPLEX, `PBMC_RST_DUPLEX); // R14
         ctrl_r.coltest <= field_def(`PBMC_B_COLTEST, `PBMC_RST_COLTEST);
      end else if (ctrl_r.reset) begin
         // writes are dropped while the reset sequence runs
         ctrl_r.restart <= 1'b0;
      end else if (wr_hit && wr_data[`PBMC_B_RESET]) begin
         ctrl_r.reset <= 1'b1; // R1
      end else begin
         if (wr_hit) begin
            ctrl_r.loop <= wr_data[`PBMC_B_LOOP]; // R2
            ctrl_r.speed <= wr_data[`PBMC_B_SPEED]; // R4
            ctrl_r.aneg <= wr_data[`PBMC_B_ANEG]; // R6
            ctrl_r.pdn <= wr_data[`PBMC_B_PDN]; // R7
            ctrl_r.iso <= wr_data[`PBMC_B_ISO]; // R9
            ctrl_r.duplex <= wr_data[`PBMC_B_DUPLEX]; // R14
            ctrl_r.coltest <= wr_data[`PBMC_B_COLTEST]; // R15
            // reserved bits are not stored at all
         end
         // set wins over the engine's start acknowledge
         if (wr_hit && wr_data[`PBMC_B_RESTART])
            ctrl_r.restart <= 1'b1; // R11
         else if (ANEG_STARTED_IN)
            ctrl_r.restart <= 1'b0; // R11 R13
      end
   end

   // soft reset countdown, reloaded by the write that starts it
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) srst_cnt_r <= 8'h00;
      else if (!ctrl_r.reset && wr_hit && wr_data[`PBMC_B_RESET])
         srst_cnt_r <= 8'(SRST_CYC); // R1
      else if (srst_cnt_r != 8'h00) srst_cnt_r <= srst_cnt_r - 8'h01;
   end

   // loopback entry at 100M blanks receive data for the dead time
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         loop_q_r <= 1'b0;
         dead_cnt_r <= '0;
      end else begin
         loop_q_r <= ctrl_r.loop;
         if (ctrl_r.loop && !loop_q_r && rd_word[`PBMC_B_SPEED])
            dead_cnt_r <= DEAD_W'(DEAD_CYC); // R3
         else if (!ctrl_r.loop) dead_cnt_r <= '0;
         else if (dead_cnt_r != '0) dead_cnt_r <= dead_cnt_r - 1'b1;
      end
   end

   // control levels to the core, straight from flops
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         SOFT_RESET_OUT <= 1'b0;
         LOOPBACK_OUT <= 1'b0;
         SPEED_100_OUT <= 1'b0;
         FULL_DUPLEX_OUT <= 1'b0;
         ANEG_EN_OUT <= 1'b0;
         ANEG_RESTART_OUT <= 1'b0;
         POWER_DOWN_OUT <= 1'b0;
      end else begin
         SOFT_RESET_OUT <= ctrl_r.reset; // R1
         LOOPBACK_OUT <= ctrl_r.loop; // R2
         SPEED_100_OUT <= rd_word[`PBMC_B_SPEED]; // R4 R6
         FULL_DUPLEX_OUT <= rd_word[`PBMC_B_DUPLEX]; // R14
         ANEG_EN_OUT <= ctrl_r.aneg; // R6
         // restart has no use without negotiation
         ANEG_RESTART_OUT <= ctrl_r.restart & ctrl_r.aneg; // R11
         POWER_DOWN_OUT <= ctrl_r.pdn; // R7
      end
   end

   // receive path toward the mac
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN || ctrl_r.pdn) begin
         // held low: no spurious edges while powered down
         MII_RX_OUT <= '0; // R8
      end else begin
         MII_RX_OUT <= CORE_RX_IN;
         if (dead_cnt_r != '0) begin
            MII_RX_OUT.dv <= 1'b0; // R3
            MII_RX_OUT.er <= 1'b0;
            MII_RX_OUT.rxd <= 4'h0;
         end
         if (ctrl_r.coltest && MII_TX_IN.en)
            MII_RX_OUT.col <= 1'b1; // R15
      end
   end

   // pad enable for every mii output
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) MII_OE_OUT <= 1'b0;
      else MII_OE_OUT <= !ctrl_r.iso; // R9
   end

   // transmit path toward the core
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN || ctrl_r.iso || ctrl_r.pdn)
         CORE_TX_OUT <= '0; // R9
      else CORE_TX_OUT <= MII_TX_IN;
   end

   // checks
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   property p_srst_hold;
      $rose(ctrl_r.reset) |-> ctrl_r.reset [*8];
   endproperty
   a_srst_hold: assert property (p_srst_hold) // R1
      else $error("reset bit dropped early");

   property p_srst_end;
      ctrl_r.reset && srst_cnt_r == 8'h01 |=> !ctrl_r.reset
         && ctrl_r.loop == field_def(`PBMC_B_LOOP, `PBMC_RST_LOOP)
         && ctrl_r.aneg == field_def(`PBMC_B_ANEG, `PBMC_RST_ANEG);
   endproperty
   a_srst_end: assert property (p_srst_end) // R1
      else $error("soft reset did not restore defaults");

   property p_dead;
      ctrl_r.loop && !loop_q_r && rd_word[`PBMC_B_SPEED]
         |=> ##1 !MII_RX_OUT.dv [*4];
   endproperty
   a_dead: assert property (p_dead) // R3
      else $error("receive data during loopback dead time");

   property p_rd_speed;
      ctrl_r.aneg |-> rd_word[`PBMC_B_SPEED] == ANEG_SPEED_IN
         && rd_word[`PBMC_B_DUPLEX] == ANEG_DUPLEX_IN;
   endproperty
   a_rd_speed: assert property (p_rd_speed) // R5
      else $error("negotiated speed or duplex not reported");

   property p_pdn_wr;
      wr_hit && ctrl_r.pdn && !ctrl_r.reset && !wr_data[`PBMC_B_RESET]
         |=> ctrl_r.loop == $past(wr_data[`PBMC_B_LOOP]);
   endproperty
   a_pdn_wr: assert property (p_pdn_wr) // R7
      else $error("write lost while powered down");

   property p_pdn_quiet;
      ctrl_r.pdn |=> MII_RX_OUT == '0 && CORE_TX_OUT == '0;
   endproperty
   a_pdn_quiet: assert property (p_pdn_quiet) // R8
      else $error("mii activity while powered down");

   property p_iso;
      ctrl_r.iso |=> !MII_OE_OUT && !CORE_TX_OUT.en;
   endproperty
   a_iso: assert property (p_iso) // R9
      else $error("isolate not honoured");

   property p_restart_hold;
      ctrl_r.restart && !ctrl_r.reset && !ANEG_STARTED_IN |=> ctrl_r.restart;
   endproperty
   a_restart_hold: assert property (p_restart_hold) // R11
      else $error("restart cleared before negotiation started");

   property p_restart_zero;
      wr_hit && !wr_data[`PBMC_B_RESTART] && ctrl_r.restart
         && !ctrl_r.reset && !ANEG_STARTED_IN |=> ctrl_r.restart;
   endproperty
   a_restart_zero: assert property (p_restart_zero) // R13
      else $error("zero write disturbed restart");

   property p_coltest;
      ctrl_r.coltest && !ctrl_r.pdn && MII_TX_IN.en |=> MII_RX_OUT.col;
   endproperty
   a_coltest: assert property (p_coltest) // R15
      else $error("collision test did not raise col");

   property p_rsvd;
      rd_word[`PBMC_RSVD_HI:0] == `PBMC_RST_RSVD;
   endproperty
   a_rsvd: assert property (p_rsvd) // R16 R18
      else $error("reserved bits not zero");

   // writes arriving mid-sequence must not leak into the fields
   property p_srst_drop;
      ctrl_r.reset && srst_cnt_r != 8'h01 |=> $stable(ctrl_r.loop);
   endproperty
   a_srst_drop: assert property (p_srst_drop) // R1
      else $error("field changed during soft reset");

   property p_forced_speed;
      !ctrl_r.aneg |=> SPEED_100_OUT == $past(ctrl_r.speed);
   endproperty
   a_forced_speed: assert property (p_forced_speed) // R4
      else $error("forced speed not exported");

   property p_restart_out;
      ctrl_r.restart && ctrl_r.aneg |=> ANEG_RESTART_OUT;
   endproperty
   a_restart_out: assert property (p_restart_out) // R11
      else $error("restart not passed to the engine");

   property p_cov_srst;
      wr_hit && wr_data[`PBMC_B_RESET] ##1 ctrl_r.reset;
   endproperty
   c_srst: cover property (p_cov_srst);

   property p_cov_restart;
      ctrl_r.restart ##1 ANEG_STARTED_IN ##1 !ctrl_r.restart;
   endproperty
   c_restart: cover property (p_cov_restart);

   property p_cov_iso;
      $rose(ctrl_r.iso) ##2 !MII_OE_OUT;
   endproperty
   c_iso: cover property (p_cov_iso);

   property p_cov_pdn;
      wr_hit && ctrl_r.pdn ##1 !ctrl_r.pdn;
   endproperty
   c_pdn: cover property (p_cov_pdn);
endmodule

/* File: pbmc_map.svh */
// register map, reset values and timing counts of the mode control block
// assumes one 100 MHz system clock; included by bare name
`ifndef PBMC_MAP_SVH
`define PBMC_MAP_SVH

// management register address of the control word
`define PBMC_REG_ADDR 5'h00
// field positions inside the 16-bit control word
`define PBMC_B_RESET 15
`define PBMC_B_LOOP 14
`define PBMC_B_SPEED 13
`define PBMC_B_ANEG 12
`define PBMC_B_PDN 11
`define PBMC_B_ISO 10
`define PBMC_B_RESTART 9
`define PBMC_B_DUPLEX 8
`define PBMC_B_COLTEST 7
`define PBMC_RSVD_HI 6
// reset values of each field
`define PBMC_RST_RESET 1'b0
`define PBMC_RST_LOOP 1'b0
`define PBMC_RST_SPEED 1'b1
`define PBMC_RST_ANEG 1'b1
`define PBMC_RST_PDN 1'b0
`define PBMC_RST_ISO 1'b0
`define PBMC_RST_RESTART 1'b0
`define PBMC_RST_DUPLEX 1'b1
`define PBMC_RST_COLTEST 1'b0
`define PBMC_RST_RSVD 7'h00
// timing: clock rate and times in their own units
`define PBMC_CLK_KHZ 100000
`define PBMC_DEAD_MS 1300
`define PBMC_SRST_NS 1000
`define PBMC_SRST_CYC ((`PBMC_SRST_NS * (`PBMC_CLK_KHZ / 1000) + 999) / 1000)
`define PBMC_DEAD_CYC (`PBMC_DEAD_MS * `PBMC_CLK_KHZ)
// management frame: preamble ones, header bits after the start zero
`define PBMC_PRE_ONES 6'd32
`define PBMC_HDR_BITS 4'd13
`define PBMC_OP_RD 2'b10
`define PBMC_OP_WR 2'b01
`define PBMC_ST 2'b01

`endif

/* File: pbmc_pkg.sv */
// types shared by the mode control block and its management slave
// assumes pbmc_map.svh supplies the numeric constants
package pbmc_pkg;
   // control fields of the mode control word
   typedef struct packed {
      logic reset;
      logic loop;
      logic speed;
      logic aneg;
      logic pdn;
      logic iso;
      logic restart;
      logic duplex;
      logic coltest;
   } pbmc_ctrl_type;
   // receive side of the mac interface
   typedef struct packed {
      logic dv;
      logic er;
      logic crs;
      logic col;
      logic [3:0] rxd;
   } pbmc_rx_type;
   // transmit side of the mac interface
   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] txd;
   } pbmc_tx_type;
   // management frame states
   typedef enum logic [2:0] {
      PBMC_ST_PRE, PBMC_ST_HDR, PBMC_ST_TA, PBMC_ST_RD, PBMC_ST_WR
   } pbmc_mdio_state_type;
endpackage

/* File: pbmc_mdio.sv */
// serial management slave: decodes read and write frames
// assumes mdc and mdio are synchronous to the system clock
`timescale 1ns/100ps
`include "pbmc_map.svh"
module pbmc_mdio (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // serial pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out,
   // own address
   input wire logic [4:0] phyad_in,
   // register side
   input wire logic [15:0] rd_data_in,
   output logic [4:0] regad_out,
   output logic wr_stb_out,
   output logic [15:0] wr_data_out
);
   import pbmc_pkg::*;
   pbmc_mdio_state_type state_r; // frame position
   logic mdc_q_r; // last mdc level
   logic [5:0] pre_r; // preamble ones seen
   logic [4:0] cnt_r; // bit counter
   logic [15:0] sh_r; // shift register
   logic is_rd_r; // current frame is a read
   logic rise; // mdc rising edge

   assign rise = mdc_in & ~mdc_q_r;

   // edge detect
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) mdc_q_r <= 1'b0;
      else mdc_q_r <= mdc_in;
   end

   // frame walker, one step per mdc rise
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= PBMC_ST_PRE;
         pre_r <= 6'h00;
         cnt_r <= 5'h00;
         sh_r <= 16'h0000;
         is_rd_r <= 1'b0;
         mdio_out <= 1'b1;
         mdio_oe_out <= 1'b0;
         regad_out <= 5'h00;
         wr_stb_out <= 1'b0;
         wr_data_out <= 16'h0000;
      end else begin
         wr_stb_out <= 1'b0;
         if (rise) begin
            case (state_r)
               PBMC_ST_PRE: begin
                  // a zero after enough ones opens the frame
                  if (mdio_in) begin
                     if (pre_r != `PBMC_PRE_ONES) pre_r <= pre_r + 6'h01;
                  end else if (pre_r == `PBMC_PRE_ONES) begin
                     state_r <= PBMC_ST_HDR;
                     sh_r <= 16'h0000;
                     cnt_r <= 5'h00;
                  end else pre_r <= 6'h00;
               end
               PBMC_ST_HDR: begin
                  sh_r <= {sh_r[14:0], mdio_in};
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r == 5'({1'b0, `PBMC_HDR_BITS} - 5'h01)) begin
                     pre_r <= 6'h00;
                     cnt_r <= 5'h00;
                     regad_out <= {sh_r[3:0], mdio_in};
                     is_rd_r <= sh_r[10:9] == `PBMC_OP_RD;
                     // foreign address or bad start: back to idle
                     // the start zero went to the preamble hunt, so
                     // only its trailing one is left, oldest in sh_r
                     if ({1'b0, sh_r[11]} == `PBMC_ST &&
                         sh_r[8:4] == phyad_in &&
                         (sh_r[10:9] == `PBMC_OP_RD ||
                          sh_r[10:9] == `PBMC_OP_WR))
                        state_r <= PBMC_ST_TA;
                     else state_r <= PBMC_ST_PRE;
                  end
               end
               PBMC_ST_TA: begin
                  cnt_r <= cnt_r + 5'h01;
                  if (is_rd_r) begin
                     // drive the turnaround zero, then data
                     mdio_oe_out <= 1'b1;
                     mdio_out <= 1'b0;
                     sh_r <= rd_data_in;
                     cnt_r <= 5'h00;
                     state_r <= PBMC_ST_RD;
                  end else if (cnt_r == 5'h01) begin
                     cnt_r <= 5'h00;
                     state_r <= PBMC_ST_WR;
                  end
               end
               PBMC_ST_RD: begin
                  cnt_r <= cnt_r + 5'h01;
                  mdio_out <= sh_r[15];
                  sh_r <= {sh_r[14:0], 1'b0};
                  if (cnt_r == 5'h10) begin
                     mdio_oe_out <= 1'b0;
                     mdio_out <= 1'b1;
                     state_r <= PBMC_ST_PRE;
                  end
               end
               PBMC_ST_WR: begin
                  cnt_r <= cnt_r + 5'h01;
                  sh_r <= {sh_r[14:0], mdio_in};
                  if (cnt_r == 5'h0f) begin
                     wr_stb_out <= 1'b1;
                     wr_data_out <= {sh_r[14:0], mdio_in};
                     state_r <= PBMC_ST_PRE;
                  end
               end
               default: state_r <= PBMC_ST_PRE;
            endcase
         end
      end
   end
endmodule

/* File: pbmc_mgmt_model.sv */
// management master model: sends read and write frames on mdc/mdio
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/100ps
module pbmc_mgmt_model (
   // system clock paces the management clock
   input wire logic clk_in,
   // resolved data line
   input wire logic mdio_in,
   // management pins driven by the master
   output logic mdc_out,
   output logic mdio_out,
   output logic mdio_oe_out
);
   logic [15:0] rd_sh; // read data collector
   // clock stands low and line is released between frames
   initial begin
      mdc_out = 1'b0;
      mdio_out = 1'b1;
      mdio_oe_out = 1'b0;
      rd_sh = 16'h0000;
   end
   // one bit: two clocks low, then two high; line sampled before rise
   task automatic bit_cyc(input logic v, input logic drv);
      @(posedge clk_in);
      #1 mdc_out = 1'b0;
      mdio_oe_out = drv;
      mdio_out = v;
      @(posedge clk_in);
      @(posedge clk_in);
      #1 rd_sh = {rd_sh[14:0], mdio_in};
      mdc_out = 1'b1;
      @(posedge clk_in);
   endtask
   // whole frame; read data are the last sixteen samples
   task automatic frame(input logic wr, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic [13:0] hdr;
      logic [17:0] tail;
      hdr = {2'b01, (wr ? 2'b01 : 2'b10), phy, ra};
      tail = {2'b10, wd};
      repeat (32) bit_cyc(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1);
      // turnaround released on reads so the device can drive
      for (int i = 17; i >= 0; i--) bit_cyc(tail[i], wr);
      @(posedge clk_in);
      #1 mdc_out = 1'b0;
      mdio_oe_out = 1'b0;
      rd = rd_sh;
   endtask
endmodule

/* File: phy_basic_mode_control_tb_top.sv */
// self-checking bench of the mode control register and its mii gating
// assumes design files and pbmc_mgmt_model are compiled before it
`timescale 1ns/100ps
module phy_basic_mode_control_tb_top;
   import pbmc_pkg::*;
   localparam logic [4:0] PHY = 5'h03; // own address
   localparam int DEAD = 20; // shortened loopback blanking
   logic clk, rst_n, mdc, mdio_w, m_out, m_oe, d_out, d_oe, mii_oe;
   logic an_spd, an_dpx, an_st, srst, loop, spd, dpx, an_en, rstrt, pdn;
   logic [15:0] strap, rdv;
   pbmc_tx_type tx, ctx;
   pbmc_rx_type crx, rx;
   int num_errors, tests_run;
   // pull-up when neither end drives the data line
   assign mdio_w = d_oe ? d_out : (m_oe ? m_out : 1'b1);
   // collision test field comes from a strap
   pbmc_top #(.DEAD_CYC(DEAD), .PIN_MASK(16'h0080)) uut (
      .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .MDC_IN(mdc),
      .MDIO_IN(mdio_w), .MDIO_OUT(d_out), .MDIO_OE_OUT(d_oe),
      .PHYAD_IN(PHY), .STRAP_IN(strap), .ANEG_SPEED_IN(an_spd),
      .ANEG_DUPLEX_IN(an_dpx), .ANEG_STARTED_IN(an_st),
      .MII_TX_IN(tx), .MII_RX_OUT(rx), .MII_OE_OUT(mii_oe),
      .CORE_RX_IN(crx), .CORE_TX_OUT(ctx), .SOFT_RESET_OUT(srst),
      .LOOPBACK_OUT(loop), .SPEED_100_OUT(spd),
      .FULL_DUPLEX_OUT(dpx), .ANEG_EN_OUT(an_en),
      .ANEG_RESTART_OUT(rstrt), .POWER_DOWN_OUT(pdn));
   pbmc_mgmt_model mgmt (.clk_in(clk), .mdio_in(mdio_w),
      .mdc_out(mdc), .mdio_out(m_out), .mdio_oe_out(m_oe));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // frame with a settling gap for the stored word
   task automatic xf(input logic w, input logic [4:0] p,
                     input logic [4:0] a, input logic [15:0] d);
      mgmt.frame(w, p, a, d, rdv);
      repeat (3) @(posedge clk);
      // leave the edge so callers drive inputs off the sampling edge
      #1;
   endtask
   task automatic wr(input logic [15:0] d);
      xf(1'b1, PHY, 5'h00, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      xf(1'b0, PHY, a, 16'h0000);
      chk(rdv, e);
   endtask
   task automatic wait_drv(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // reset word, strap-loaded field
   task automatic t_default;
      rd(5'h00, 16'h3180);
      chk(spd, 1'b1);
      chk(an_en, 1'b1);
   endtask
   // negotiated readback, then forced speed and duplex
   task automatic t_neg;
      wait_drv(1);
      an_spd = 1'b0;
      an_dpx = 1'b0;
      rd(5'h00, 16'h1080);
      wr(16'h2100);
      rd(5'h00, 16'h2100);
      chk({spd, dpx}, 2'b11);
      wr(16'h0000);
      rd(5'h00, 16'h0000);
      chk({spd, dpx}, 2'b00);
   endtask
   // other address and other register are refused
   task automatic t_refuse;
      xf(1'b1, PHY + 5'h01, 5'h00, 16'h2100);
      rd(5'h00, 16'h0000);
      rd(5'h01, 16'h0000);
   endtask
   // restart holds until the engine starts, zero write is ignored
   task automatic t_restart;
      wr(16'h1200);
      rd(5'h00, 16'h1200);
      chk(rstrt, 1'b1);
      wr(16'h1000);
      rd(5'h00, 16'h1200);
      wait_drv(1);
      an_st = 1'b1;
      wait_drv(1);
      an_st = 1'b0;
      rd(5'h00, 16'h1000);
      chk(rstrt, 1'b0);
   endtask
   // collision test, isolate and power-down on the mii
   task automatic t_mii;
      wr(16'h1080);
      wait_drv(1);
      tx.en = 1'b1;
      wait_drv(2);
      chk(rx.col, 1'b1);
      chk(ctx.en, 1'b1);
      tx.en = 1'b0;
      crx = 8'ha5;
      wait_drv(2);
      chk(rx, 8'ha5);
      chk(mii_oe, 1'b1);
      wr(16'h1400);
      tx.en = 1'b1;
      wait_drv(2);
      chk({mii_oe, ctx}, 7'h00);
      rd(5'h00, 16'h1400);
      wr(16'h1800);
      chk({pdn, rx, ctx}, 15'h4000);
      rd(5'h00, 16'h1800);
      wait_drv(1);
      tx.en = 1'b0;
   endtask
   // 100M loopback blanks receive data for the dead time
   task automatic t_loop;
      wr(16'h6100);
      chk({loop, rx.dv}, 2'b10);
      wait_drv(DEAD + 5);
      chk({rx.dv, rx.rxd}, 5'h15);
      wr(16'h2100);
      chk(loop, 1'b0);
   endtask
   // soft reset runs its sequence and restores defaults
   task automatic t_soft;
      wait_drv(1);
      an_spd = 1'b1;
      an_dpx = 1'b1;
      wr(16'h8000);
      chk(srst, 1'b1);
      wait_drv(110);
      chk(srst, 1'b0);
      rd(5'h00, 16'h3180);
   endtask
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // a hang is cut short well beyond the expected run
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
   // main sequence
   initial begin
      num_errors = 0;
      tests_run = 0;
      rst_n = 1'b0;
      strap = 16'h0080;
      tx = '0;
      crx = '0;
      an_spd = 1'b1;
      an_dpx = 1'b1;
      an_st = 1'b0;
      wait_drv(4);
      rst_n = 1'b1;
      wait_drv(2);
      t_default();
      t_neg();
      t_refuse();
      t_restart();
      t_mii();
      t_loop();
      t_soft();
      give_verdict();
   end
endmodule
